// ---- core/cmpsc_ctrl.sv ----
// Summary of operation
// - Supply rising above turn-on threshold starts soft start.
// - Soft-start duty reference rises in 32 steps, one per counter advance.
// - Soft-start counter advances every 600 us, widening duty gradually.
// - Soft start ends 20 ms after switch-on; soft-start limit then removed.
// - Duty grows from zero to maximum; soft start reruns at every restart.
// - Switching clock 65 kHz, jittered by 2.6 kHz over a 4 ms period.
// - Gate on-time never exceeds 0.75 of the switching period.
// - No jitter during soft start; jitter only in normal and burst operation.
// - Oscillator pulse sets the latch; PWM, soft-start or limit comparator resets it.
// - Latch in reset drives the gate off at once.
// - Supply below undervoltage threshold forces the gate low.
// - Sensed current above the limit resets the latch in that cycle.
// - Current sense ignored for 220 ns after each gate turn-on.
// - Burst mode switches to the reduced current-limit comparator.
// - 20 ms blanking precedes entry into burst or auto-restart.
// - Extendable blanking releases pin clamp, waits for pin comparator.
// - A further 30 us spike blanking precedes auto-restart.
// - Burst uses basic blanking only; auto-restart uses basic or extended.
// - High-voltage startup path stays disabled in burst mode.
// - Supply below turn-off threshold clears the soft-start counter.
// - Burst entered only if feedback still low after 20 ms count.
// - Feedback above overload level starts the overload blanking count.
module cmpsc_ctrl #(
  parameter int P_SS_STEP_CYC    = cmpsc_pkg::SS_STEP_CYC,
  parameter int P_SS_DUR_CYC     = cmpsc_pkg::SS_DUR_CYC,
  parameter int P_BLANK_CYC      = cmpsc_pkg::BLANK_CYC,
  parameter int P_JIT_PERIOD_CYC = cmpsc_pkg::JIT_PERIOD_CYC
) (
  input  wire logic        i_ref_clk,        // 125 MHz clock
  input  wire logic        i_rst_n,          // Async reset, active low
  input  wire logic        i_vcc_ok,         // Supply above turn-on, stays until below turn-off
  input  wire logic        i_pwm_cmp,        // Amplified sense above feedback
  input  wire logic        i_ss_cmp,         // Soft-start comparator trip
  input  wire logic        i_peak_cmp,       // Sense above current limit threshold
  input  wire logic        i_burst_cmp,      // Sense above reduced burst limit
  input  wire logic        i_fb_low,         // Feedback below burst entry level
  input  wire logic        i_fb_high,        // Feedback above overload level
  input  wire logic        i_blank_pin_high, // Blanking pin reached upper level
  input  wire logic [3:0]  i_avs_address,    // Byte address
  input  wire logic        i_avs_read,       // Read request
  input  wire logic        i_avs_write,      // Write request
  input  wire logic [31:0] i_avs_writedata,  // Write data
  input  wire logic [3:0]  i_avs_byteenable, // Byte enables
  output logic      [31:0] o_avs_readdata,   // Read data
  output logic             o_avs_waitrequest,// Wait request
  output logic             o_gate,           // Gate drive
  output logic [4:0]       o_softstart_ref,  // Soft-start duty reference step
  output logic             o_softstart,      // Soft start in progress
  output logic             o_burst,          // Burst mode active
  output logic             o_auto_restart,   // Auto-restart latched off
  output logic             o_clamp_release,  // Blanking pin clamp switch open
  output logic             o_hv_startup_en   // High-voltage startup path enabled
);

  localparam int JIT_STEP_CYC = P_JIT_PERIOD_CYC / (4 * cmpsc_pkg::JIT_DEV_CYC);

  // Three-stage synchronisers with agreement filter
  logic [cmpsc_pkg::CMP_N-1:0] cmp_raw;
  logic [cmpsc_pkg::CMP_N-1:0] cmp_s;
  assign cmp_raw = {i_blank_pin_high, i_fb_high, i_fb_low, i_burst_cmp,
                    i_peak_cmp, i_ss_cmp, i_pwm_cmp, i_vcc_ok};

  genvar g;
  generate
    for (g = 0; g < cmpsc_pkg::CMP_N; g++) begin : g_sync
      logic [2:0] sh_q;
      logic       filt_q;
      // New level accepted only once stages two and three agree
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sh_q   <= 3'h0;
          filt_q <= 1'b0;
        end else begin
          sh_q   <= {sh_q[1:0], cmp_raw[g]};
          filt_q <= (sh_q[1] == sh_q[2]) ? sh_q[2] : filt_q;
        end
      end
      assign cmp_s[g] = filt_q;
    end
  endgenerate

  wire vcc_ok  = cmp_s[cmpsc_pkg::CMP_VCC_OK];
  wire fb_low  = cmp_s[cmpsc_pkg::CMP_FB_LOW];
  wire fb_high = cmp_s[cmpsc_pkg::CMP_FB_HIGH];
  wire pin_hi  = cmp_s[cmpsc_pkg::CMP_BLANK_HI];

  // State and counters
  cmpsc_pkg::cmpsc_state_e state_q, state_d;
  logic [21:0] long_q, long_d;
  logic [16:0] step_tmr_q, step_tmr_d;
  logic [4:0]  step_q, step_d;
  logic        clamp_q, clamp_d;
  logic [11:0] spike_q, spike_d;
  logic [11:0] osc_q;
  logic [10:0] on_q;
  logic [4:0]  leb_q;
  logic        latch_q, latch_d;
  logic signed [7:0] jit_q;
  logic        jit_up_q;
  logic [10:0] jit_tmr_q;
  logic        ext_blank_q;
  logic        jit_en_q;

  wire running = (state_q == cmpsc_pkg::ST_SOFT) || (state_q == cmpsc_pkg::ST_NORMAL) ||
                 (state_q == cmpsc_pkg::ST_BURST);
  wire in_soft = (state_q == cmpsc_pkg::ST_SOFT);
  wire in_burst = (state_q == cmpsc_pkg::ST_BURST);

  // Jittered period; frozen at nominal outside normal and burst operation
  wire        jit_active = ((state_q == cmpsc_pkg::ST_NORMAL) || in_burst) && jit_en_q;
  wire [11:0] period     = 12'(cmpsc_pkg::OSC_PERIOD_CYC) + {{4{jit_q[7]}}, jit_q};
  wire        osc_tick   = running && (osc_q >= period - 12'h001);
  wire        jit_tick   = (jit_tmr_q == 11'(JIT_STEP_CYC - 1));
  wire signed [7:0] jit_lim = 8'(cmpsc_pkg::JIT_DEV_CYC);

  // Duty limits: 0.75 of period, scaled by the soft-start step while ramping
  wire [10:0] max_on  = 11'((period >> cmpsc_pkg::MAXIMUM_DUTY_LIMIT_SH_A) + (period >> cmpsc_pkg::MAXIMUM_DUTY_LIMIT_SH_B));
  wire [15:0] ss_prod = max_on * step_q;
  wire [10:0] ss_on   = 11'(ss_prod >> 5);
  wire [10:0] on_lim  = in_soft ? ss_on : max_on;
  wire        lim_hit = on_q >= on_lim;

  // Sense path blanked for the first cycles after turn-on
  wire leb_done = (leb_q == 5'(cmpsc_pkg::LEB_CYC));
  // Peak limit uses the raw comparator so shutdown does not wait for synchronisation
  wire peak_raw = in_burst ? i_burst_cmp : i_peak_cmp;
  wire cs_reset = leb_done && (peak_raw || cmp_s[cmpsc_pkg::CMP_PWM] ||
                               cmp_s[cmpsc_pkg::CMP_SS]);

  // Latch: set by oscillator pulse, reset by the PWM, soft-start or active limit comparator or the duty limit
  always_comb begin
    latch_d = latch_q;
    if (!running || !vcc_ok) begin
      latch_d = 1'b0;
    end else if (osc_tick && on_lim != 11'h000) begin
      latch_d = 1'b1;
    end else if (cs_reset || lim_hit) begin
      latch_d = 1'b0;
    end
  end

  // Oscillator, on-time and blanking counters
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_q   <= 12'h000;
      on_q    <= 11'h000;
      leb_q   <= 5'h00;
      latch_q <= 1'b0;
    end else begin
      osc_q   <= (osc_tick || !running) ? 12'h000 : osc_q + 12'h001;
      on_q    <= (osc_tick || !latch_q) ? 11'h000 : on_q + 11'h001;
      leb_q   <= (osc_tick || !latch_q) ? 5'h00 : (leb_done ? leb_q : leb_q + 5'h01);
      latch_q <= latch_d;
    end
  end

  // Triangular sweep of the period offset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      jit_q     <= 8'sh00;
      jit_up_q  <= 1'b1;
      jit_tmr_q <= 11'h000;
    end else if (!jit_active) begin
      jit_q     <= 8'sh00;
      jit_up_q  <= 1'b1;
      jit_tmr_q <= 11'h000;
    end else begin
      jit_tmr_q <= jit_tick ? 11'h000 : jit_tmr_q + 11'h001;
      if (jit_tick) begin
        jit_q    <= jit_up_q ? jit_q + 8'sh01 : jit_q - 8'sh01;
        jit_up_q <= jit_up_q ? (jit_q + 8'sh01 < jit_lim) : (jit_q - 8'sh01 <= -jit_lim);
      end
    end
  end

  // Mode sequencing: soft start, normal, burst, blanking and restart
  always_comb begin
    state_d    = state_q;
    long_d     = long_q + 22'h000001;
    step_tmr_d = step_tmr_q;
    step_d     = step_q;
    clamp_d    = clamp_q;
    spike_d    = 12'h000;
    if (!vcc_ok) begin
      state_d    = cmpsc_pkg::ST_OFF;
      long_d     = 22'h000000;
      step_tmr_d = 17'h00000;
      step_d     = 5'h00;
      clamp_d    = 1'b0;
    end else begin
      unique case (state_q)
        cmpsc_pkg::ST_OFF: begin
          long_d = 22'h000000;
          state_d = cmpsc_pkg::ST_SOFT;
        end
        cmpsc_pkg::ST_SOFT: begin
          step_tmr_d = (step_tmr_q == 17'(P_SS_STEP_CYC - 1)) ? 17'h00000 : step_tmr_q + 17'h00001;
          if (step_tmr_q == 17'(P_SS_STEP_CYC - 1) && step_q != 5'(cmpsc_pkg::SS_STEPS - 1)) begin
            step_d = step_q + 5'h01;
          end
          if (long_q == 22'(P_SS_DUR_CYC - 1)) begin
            state_d = cmpsc_pkg::ST_NORMAL;
            long_d  = 22'h000000;
          end
        end
        cmpsc_pkg::ST_NORMAL: begin
          if (fb_low) begin
            clamp_d = 1'b0;
            if (long_q == 22'(P_BLANK_CYC - 1)) begin
              state_d = cmpsc_pkg::ST_BURST;
              long_d  = 22'h000000;
            end
          end else if (fb_high) begin
            if (long_q == 22'(P_BLANK_CYC - 1)) begin
              clamp_d = 1'b1;
              long_d  = long_q;
            end
            if (clamp_q && (pin_hi || !ext_blank_q)) begin
              spike_d = spike_q + 12'h001;
              if (spike_q == 12'(cmpsc_pkg::SPIKE_CYC - 1)) begin
                state_d = cmpsc_pkg::ST_RESTART;
              end
            end
          end else begin
            long_d  = 22'h000000;
            clamp_d = 1'b0;
          end
        end
        cmpsc_pkg::ST_BURST: begin
          long_d = 22'h000000;
          if (fb_high) begin
            state_d = cmpsc_pkg::ST_NORMAL;
          end
        end
        cmpsc_pkg::ST_RESTART: begin
          // Held off until the supply collapses; the next turn-on reruns soft start
          long_d  = 22'h000000;
          clamp_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= cmpsc_pkg::ST_OFF;
      long_q     <= 22'h000000;
      step_tmr_q <= 17'h00000;
      step_q     <= 5'h00;
      clamp_q    <= 1'b0;
      spike_q    <= 12'h000;
    end else begin
      state_q    <= state_d;
      long_q     <= long_d;
      step_tmr_q <= step_tmr_d;
      step_q     <= step_d;
      clamp_q    <= clamp_d;
      spike_q    <= spike_d;
    end
  end

  // Status outputs registered from the next state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_softstart     <= 1'b0;
      o_burst         <= 1'b0;
      o_auto_restart  <= 1'b0;
      o_hv_startup_en <= 1'b1;
    end else begin
      o_softstart     <= (state_d == cmpsc_pkg::ST_SOFT);
      o_burst         <= (state_d == cmpsc_pkg::ST_BURST);
      o_auto_restart  <= (state_d == cmpsc_pkg::ST_RESTART);
      o_hv_startup_en <= (state_d == cmpsc_pkg::ST_OFF) || (state_d == cmpsc_pkg::ST_RESTART);
    end
  end

  assign o_gate          = latch_q;
  assign o_softstart_ref = step_q;
  assign o_clamp_release = clamp_q;

  // Register bus: one wait cycle, then the answer in the cycle waitrequest is low
  wire bus_req   = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  wire bus_take  = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  wire sel_ctrl  = (i_avs_address == cmpsc_pkg::REG_CTRL);
  wire sel_stat  = (i_avs_address == cmpsc_pkg::REG_STATUS);
  wire sel_count = (i_avs_address == cmpsc_pkg::REG_COUNT);
  wire ctrl_we   = bus_take && i_avs_write && sel_ctrl && i_avs_byteenable[0];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) begin
      rd_mux[cmpsc_pkg::CTRL_EXT_BLANK] = ext_blank_q;
      rd_mux[cmpsc_pkg::CTRL_JITTER_EN] = jit_en_q;
    end else if (sel_stat) begin
      rd_mux[cmpsc_pkg::STAT_STATE_LSB +: 3] = state_q;
      rd_mux[cmpsc_pkg::STAT_STEP_LSB +: 5]  = step_q;
      rd_mux[cmpsc_pkg::STAT_GATE]           = latch_q;
      rd_mux[cmpsc_pkg::STAT_CLAMP_REL]      = clamp_q;
    end else if (sel_count) begin
      rd_mux[21:0] = long_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
      ext_blank_q       <= cmpsc_pkg::CTRL_EXT_BLANK_RST;
      jit_en_q          <= cmpsc_pkg::CTRL_JITTER_RST;
    end else begin
      o_avs_waitrequest <= !bus_req;
      if (bus_req && i_avs_read) begin
        o_avs_readdata <= rd_mux;
      end
      if (ctrl_we) begin
        ext_blank_q <= i_avs_writedata[cmpsc_pkg::CTRL_EXT_BLANK];
        jit_en_q    <= i_avs_writedata[cmpsc_pkg::CTRL_JITTER_EN];
      end
    end
  end

endmodule : cmpsc_ctrl

// ---- pkg/cmpsc_pkg.sv ----
package cmpsc_pkg;

  // Clock rate used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // Soft start: step interval, total duration, number of steps
  localparam int SS_STEP_US  = 600;
  localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
  localparam int SS_DUR_MS   = 20;
  localparam int SS_DUR_CYC  = SS_DUR_MS * CLK_MHZ * 1000;
  localparam int SS_STEPS    = 32;

  // Oscillator nominal frequency, jitter deviation and modulation period
  localparam int OSC_HZ         = 65000;
  localparam int OSC_PERIOD_CYC = CLK_MHZ * 1000000 / OSC_HZ;
  localparam int JIT_HZ         = 2600;
  localparam int JIT_DEV_CYC    = OSC_PERIOD_CYC - CLK_MHZ * 1000000 / (OSC_HZ + JIT_HZ);
  localparam int JIT_MS         = 4;
  localparam int JIT_PERIOD_CYC = JIT_MS * CLK_MHZ * 1000;

  // Maximum duty 0.75 as on-time = period/2 + period/4
  localparam int MAXIMUM_DUTY_LIMIT_SH_A = 1;
  localparam int MAXIMUM_DUTY_LIMIT_SH_B = 2;

  // Leading edge blanking, rounded up
  localparam int LEB_NS  = 220;
  localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;

  // Mode-entry blanking and spike blanking
  localparam int BLANK_MS      = 20;
  localparam int BLANK_CYC     = BLANK_MS * CLK_MHZ * 1000;
  localparam int SPIKE_US      = 30;
  localparam int SPIKE_CYC     = SPIKE_US * CLK_MHZ;

  // Comparator input indices
  localparam int CMP_N        = 8;
  localparam int CMP_VCC_OK   = 0;
  localparam int CMP_PWM      = 1;
  localparam int CMP_SS       = 2;
  localparam int CMP_PEAK     = 3;
  localparam int CMP_BURST    = 4;
  localparam int CMP_FB_LOW   = 5;
  localparam int CMP_FB_HIGH  = 6;
  localparam int CMP_BLANK_HI = 7;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT  = 4'h8;

  // Control fields and reset values
  localparam int CTRL_EXT_BLANK    = 0;
  localparam int CTRL_JITTER_EN    = 1;
  localparam logic CTRL_EXT_BLANK_RST = 1'b0;
  localparam logic CTRL_JITTER_RST    = 1'b1;

  // Status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STEP_LSB  = 4;
  localparam int STAT_GATE      = 9;
  localparam int STAT_CLAMP_REL = 10;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SOFT,
    ST_NORMAL,
    ST_BURST,
    ST_RESTART
  } cmpsc_state_e;

endpackage : cmpsc_pkg

// ---- testbench/cmpsc_analog_model.sv ----
module cmpsc_analog_model (
  input  wire logic        i_ref_clk,   // Clock
  input  wire logic        i_gate,      // Switch conducting
  input  wire logic        i_clamp_rel, // Pin clamp open
  input  wire logic        i_supply_up, // Supply above turn-on
  input  wire logic [1:0]  i_fb_lvl,    // 0 mid, 1 light, 2 overload
  input  wire logic [15:0] i_peak_at,   // On-cycles to limit, 0 never
  input  wire logic [15:0] i_pwm_at,    // On-cycles to feedback trip
  input  wire logic [15:0] i_bk_dly,    // Pin charge time
  output logic             o_vcc_ok,    // Supply comparator
  output logic             o_pwm_cmp,   // Feedback comparator
  output logic             o_ss_cmp,    // Soft-start comparator
  output logic             o_peak_cmp,  // Current limit
  output logic             o_burst_cmp, // Reduced limit
  output logic             o_fb_low,    // Light load
  output logic             o_fb_high,   // Overload
  output logic             o_pin_high   // Pin at upper level
);
  logic [15:0] on_q;
  logic [15:0] bk_q;

  initial begin
    {o_vcc_ok, o_pwm_cmp, o_ss_cmp, o_peak_cmp, o_burst_cmp, o_fb_low, o_fb_high, o_pin_high} = '0;
  end

  // Sense ramp rises while the switch conducts; reduced limit trips at a third of the ramp
  always @(posedge i_ref_clk) begin
    on_q        <= i_gate ? on_q + 16'h1 : 16'h0;
    bk_q        <= i_clamp_rel ? bk_q + {15'h0, bk_q != 16'hffff} : 16'h0;
    o_vcc_ok    <= i_supply_up;
    o_peak_cmp  <= i_gate && i_peak_at != 16'h0 && on_q + 16'h1 >= i_peak_at;
    o_burst_cmp <= i_gate && i_peak_at != 16'h0 && on_q + 16'h1 >= i_peak_at / 16'h3;
    o_pwm_cmp   <= i_gate && i_pwm_at != 16'h0 && on_q + 16'h1 >= i_pwm_at;
    o_ss_cmp    <= 1'b0;
    o_fb_low    <= i_fb_lvl == 2'h1;
    o_fb_high   <= i_fb_lvl == 2'h2;
    o_pin_high  <= i_clamp_rel && bk_q >= i_bk_dly;
  end
endmodule : cmpsc_analog_model

// ---- testbench/cmpsc_ctrl_chk.sv ----
module cmpsc_ctrl_chk #(
  parameter int P_SS_STEP_CYC = cmpsc_pkg::SS_STEP_CYC,
  parameter int P_SS_DUR_CYC  = cmpsc_pkg::SS_DUR_CYC,
  parameter int P_BLANK_CYC   = cmpsc_pkg::BLANK_CYC
) (
  input wire logic       i_ref_clk,       // Clock
  input wire logic       i_rst_n,         // Reset, active low
  input wire logic       i_vcc_ok,        // Supply comparator
  input wire logic       i_peak_cmp,      // Raw current limit
  input wire logic       i_fb_low,        // Light load
  input wire logic       i_fb_high,       // Overload
  input wire logic       o_gate,          // Gate drive
  input wire logic [4:0] o_softstart_ref, // Soft-start step
  input wire logic       o_softstart,     // Soft start running
  input wire logic       o_burst,         // Burst mode
  input wire logic       o_auto_restart,  // Auto-restart
  input wire logic       o_clamp_release, // Pin clamp open
  input wire logic       o_hv_startup_en  // Startup path
);
  // Longest legal on-time: slowest jittered period at 0.75, two cycles of slack for the flop
  localparam int MaxOn = (cmpsc_pkg::OSC_PERIOD_CYC + cmpsc_pkg::JIT_DEV_CYC) * 3 / 4 + 2;
  logic [31:0] on_q, ss_q, gap_q, clr_q, fbl_q, fbh_q;
  logic [3:0]  vcc_q;
  logic [4:0]  ref_q;

  // Run lengths of watched levels; vcc_q saturates so it only says "long settled"
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {on_q, ss_q, gap_q, clr_q, fbl_q, fbh_q, vcc_q, ref_q} <= '0;
    end else begin
      on_q  <= o_gate ? on_q + 32'h1 : 32'h0;
      ss_q  <= o_softstart ? ss_q + 32'h1 : 32'h0;
      gap_q <= (o_softstart_ref != ref_q) ? 32'h0 : gap_q + 32'h1;
      clr_q <= o_clamp_release ? clr_q + 32'h1 : 32'h0;
      fbl_q <= i_fb_low ? fbl_q + 32'h1 : 32'h0;
      fbh_q <= i_fb_high ? fbh_q + 32'h1 : 32'h0;
      vcc_q <= !i_vcc_ok ? 4'h0 : vcc_q + {3'h0, vcc_q != 4'hf};
      ref_q <= o_softstart_ref;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_burst_go;
    !o_burst ##1 o_burst;
  endsequence
  sequence s_restart_go;
    !o_auto_restart ##1 o_auto_restart;
  endsequence

  a_uvlo_gate_low: assert property (!i_vcc_ok [*6] |-> !o_gate)
    else $error("gate high while supply low");
  a_uvlo_step_clr: assert property (!i_vcc_ok [*6] |-> o_softstart_ref == 5'h00 && !o_softstart)
    else $error("soft start not cleared by low supply");
  a_step_plus_one: assert property ($changed(o_softstart_ref) |->
      o_softstart_ref == $past(o_softstart_ref) + 5'h01 || o_softstart_ref == 5'h00)
    else $error("soft-start step skipped");
  a_step_interval: assert property (o_softstart_ref != ref_q && o_softstart_ref >= 5'h02 |->
      gap_q == P_SS_STEP_CYC - 1)
    else $error("soft-start step spacing wrong");
  a_soft_length: assert property ($fell(o_softstart) && vcc_q == 4'hf |->
      ss_q >= P_SS_DUR_CYC - 3 && ss_q <= P_SS_DUR_CYC + 3)
    else $error("soft start length wrong");
  a_max_duty: assert property (o_gate |-> on_q < MaxOn)
    else $error("on-time beyond maximum duty");
  a_leb_hold: assert property ($fell(o_gate) && vcc_q == 4'hf && !o_auto_restart |->
      on_q >= cmpsc_pkg::LEB_CYC - 1)
    else $error("pulse ended inside blanking window");
  a_peak_cut: assert property (o_gate && on_q >= 32'd32 && i_peak_cmp |=> !o_gate)
    else $error("current limit did not end pulse");
  a_burst_no_hv: assert property (o_burst |-> !o_hv_startup_en)
    else $error("startup path on in burst");
  a_burst_blank: assert property (s_burst_go |-> fbl_q >= P_BLANK_CYC)
    else $error("burst entered before blanking");
  a_clamp_blank: assert property ($rose(o_clamp_release) |-> fbh_q >= P_BLANK_CYC)
    else $error("clamp released before blanking");
  a_restart_spike: assert property (s_restart_go |-> clr_q >= cmpsc_pkg::SPIKE_CYC - 4)
    else $error("auto-restart before spike blanking");
endmodule : cmpsc_ctrl_chk

bind cmpsc_ctrl cmpsc_ctrl_chk #(
  .P_SS_STEP_CYC(P_SS_STEP_CYC),
  .P_SS_DUR_CYC (P_SS_DUR_CYC),
  .P_BLANK_CYC  (P_BLANK_CYC)
) cmpsc_ctrl_chk_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_vcc_ok(i_vcc_ok), .i_peak_cmp(i_peak_cmp),
  .i_fb_low(i_fb_low), .i_fb_high(i_fb_high), .o_gate(o_gate), .o_softstart_ref(o_softstart_ref),
  .o_softstart(o_softstart), .o_burst(o_burst), .o_auto_restart(o_auto_restart),
  .o_clamp_release(o_clamp_release), .o_hv_startup_en(o_hv_startup_en)
);

// ---- testbench/cmpsc_ctrl_tb.sv ----
module cmpsc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WG = 4, WS = 3, WB = 2, WC = 1, WR = 0;
  localparam int PER = cmpsc_pkg::OSC_PERIOD_CYC, DEV = cmpsc_pkg::JIT_DEV_CYC;
  logic        clk, rst_n, sup, rd, wr, gate, wreq, ss, burst, rstrt, clr, hv;
  logic        vcc_ok, pwm_c, ss_c, pk_c, bu_c, fbl, fbh, pin;
  logic [1:0]  fb;
  logic [15:0] pk_at, pwm_at, bk;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [4:0]  sref;
  int          errors, cmp_count;
  wire  [4:0]  mon = {gate, ss, burst, clr, rstrt};

  cmpsc_ctrl #(.P_SS_STEP_CYC(20), .P_SS_DUR_CYC(700), .P_BLANK_CYC(200), .P_JIT_PERIOD_CYC(2960)) cmpsc_ctrl_i (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_vcc_ok(vcc_ok), .i_pwm_cmp(pwm_c), .i_ss_cmp(ss_c),
    .i_peak_cmp(pk_c), .i_burst_cmp(bu_c), .i_fb_low(fbl), .i_fb_high(fbh), .i_blank_pin_high(pin),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_gate(gate),
    .o_softstart_ref(sref), .o_softstart(ss), .o_burst(burst), .o_auto_restart(rstrt),
    .o_clamp_release(clr), .o_hv_startup_en(hv));
  cmpsc_analog_model cmpsc_analog_model_i (
    .i_ref_clk(clk), .i_gate(gate), .i_clamp_rel(clr), .i_supply_up(sup), .i_fb_lvl(fb),
    .i_peak_at(pk_at), .i_pwm_at(pwm_at), .i_bk_dly(bk), .o_vcc_ok(vcc_ok), .o_pwm_cmp(pwm_c),
    .o_ss_cmp(ss_c), .o_peak_cmp(pk_c), .o_burst_cmp(bu_c), .o_fb_low(fbl), .o_fb_high(fbh),
    .o_pin_high(pin));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : chk_in

  // Bus cycle: hold the request until waitrequest is seen low, take data at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] d);
    int n;
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    rd    <= !w;
    wr    <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk({31'h0, n < 50}, 32'h1);
  endtask : bus

  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[k] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, mon[k] === v}, 32'h1);
  endtask : wait_for

  // One whole gate pulse: on-time and the period to the next rise
  task automatic meas(output int on, output int per);
    wait_for(WG, 1'b0, 5000);
    wait_for(WG, 1'b1, 5000);
    on = 0;
    while (gate === 1'b1 && on < 5000) begin
      @(posedge clk);
      on++;
    end
    per = on;
    while (gate !== 1'b1 && per < 5000) begin
      @(posedge clk);
      per++;
    end
  endtask : meas

  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, cmpsc_pkg::REG_CTRL, 32'h0, d);
    chk(d, 32'h00000002);
    bus(1'b1, cmpsc_pkg::REG_CTRL, 32'h00000001, d);
    bus(1'b1, 4'hc, 32'hffffffff, d);
    bus(1'b0, 4'hc, 32'h0, d);
    chk(d, 32'h00000000);
    bus(1'b0, cmpsc_pkg::REG_CTRL, 32'h0, d);
    chk(d, 32'h00000001);
    bus(1'b0, cmpsc_pkg::REG_STATUS, 32'h0, d);
    chk({29'h0, d[2:0]}, 32'h0);
    chk({31'h0, ss}, 32'h0);
    bus(1'b1, cmpsc_pkg::REG_CTRL, 32'h00000000, d);
  endtask : t_regs

  task automatic t_soft;
    int n;
    logic [4:0] mx;
    logic [31:0] d;
    sup <= 1'b1;
    wait_for(WS, 1'b1, 20);
    n = 0;
    mx = 5'h00;
    while (ss === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
      if (sref > mx) mx = sref;
    end
    chk_in(n, 697, 703);
    chk({27'h0, mx}, 32'h1f);
    bus(1'b0, cmpsc_pkg::REG_STATUS, 32'h0, d);
    chk({29'h0, d[2:0]}, 32'h2);
  endtask : t_soft

  task automatic t_limits;
    int on, per;
    pk_at <= 16'd100;
    meas(on, per);
    chk_in(on, 100, 104);
    pk_at <= 16'd5;
    meas(on, per);
    chk_in(on, cmpsc_pkg::LEB_CYC, cmpsc_pkg::LEB_CYC + 4);
    pk_at  <= 16'd0;
    pwm_at <= 16'd300;
    meas(on, per);
    chk_in(on, 300, 308);
    pwm_at <= 16'd0;
    meas(on, per);
    chk_in(on, (PER >> 1) + (PER >> 2) - 2, (PER >> 1) + (PER >> 2) + 2);
    chk_in(per, PER - 1, PER + 1);
  endtask : t_limits

  task automatic t_jitter;
    int on, per, mn, mx;
    logic [31:0] d;
    bus(1'b1, cmpsc_pkg::REG_CTRL, 32'h00000002, d);
    mn = 99999;
    mx = 0;
    repeat (12) begin
      meas(on, per);
      if (per < mn) mn = per;
      if (per > mx) mx = per;
    end
    chk_in(mn, PER - DEV - 2, PER);
    chk_in(mx, PER, PER + DEV + 2);
    chk_in(mx - mn, 60, 2 * DEV + 4);
  endtask : t_jitter

  task automatic t_restart;
    int n, on, per;
    logic [31:0] d;
    bus(1'b1, cmpsc_pkg::REG_CTRL, 32'h00000001, d);
    fb <= 2'h1;
    wait_for(WB, 1'b1, 400);
    chk({31'h0, hv}, 32'h0);
    pk_at <= 16'd300;
    meas(on, per);
    chk_in(on, 100, 106);
    pk_at <= 16'd0;
    fb    <= 2'h2;
    bk    <= 16'd100;
    wait_for(WB, 1'b0, 20);
    wait_for(WC, 1'b1, 400);
    n = 0;
    while (rstrt !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    chk_in(n, 100 + cmpsc_pkg::SPIKE_CYC, 112 + cmpsc_pkg::SPIKE_CYC);
    fb  <= 2'h0;
    sup <= 1'b0;
    repeat (8) @(posedge clk);
    chk({27'h0, sref}, 32'h0);
    sup <= 1'b1;
    wait_for(WS, 1'b1, 20);
    wait_for(WG, 1'b1, 4000);
    sup <= 1'b0;
    repeat (7) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    // Basic blanking alone: pin never reaches its level, restart must still come
    sup <= 1'b1;
    bk  <= 16'hffff;
    fb  <= 2'h2;
    bus(1'b1, cmpsc_pkg::REG_CTRL, 32'h00000000, d);
    wait_for(WR, 1'b1, 5000);
  endtask : t_restart

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Longest path is about 77k cycles; give it about a quarter more than that
  initial begin
    #(8 * 95000);
    errors++;
    final_report;
  end

  initial begin
    {errors, cmp_count} = '0;
    {rst_n, sup, rd, wr, fb, pk_at, pwm_at, bk, addr, wdata} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_soft;
    t_limits;
    t_jitter;
    t_restart;
    final_report;
  end
endmodule : cmpsc_ctrl_tb
